// >>> hdl/pao_top.v
// port a/b alternate-function override logic
`include "pao_defs.vh"
`default_nettype none
module pao_top #(
    parameter WIDTH = `PAO_PORT_WIDTH
) (
    input wire ref_clk,
    input wire rst,
    input wire [WIDTH-1:0] port_a_dir,
    input wire [WIDTH-1:0] port_a_out,
    input wire [WIDTH-1:0] port_b_dir,
    input wire [WIDTH-1:0] port_b_out,
    input wire [WIDTH-1:0] port_a_pin,
    input wire [WIDTH-1:0] port_b_pin,
    input wire pullup_disable,
    input wire [WIDTH-1:0] pin_change_source_a,
    input wire [WIDTH-1:0] pin_change_source_b,
    input wire pin_change_group_enable,
    input wire [WIDTH-1:0] analog_digital_disable_a,
    input wire [WIDTH-1:0] analog_digital_disable_b,
    input wire serial_alt_position_select,
    input wire serial_two_line_mode,
    input wire serial_three_line_mode,
    input wire serial_clock_hold,
    input wire serial_clock_toggle_enable,
    input wire serial_data_out,
    input wire serial_data_hold,
    input wire start_detect_irq_enable,
    input wire external_irq_one,
    input wire reset_pin_disable_fuse,
    input wire debug_line_enable_fuse,
    input wire debug_line_transmit,
    input wire internal_oscillator_select,
    input wire external_clock_select,
    input wire timer_compare_out_a,
    input wire timer_compare_a_enable,
    input wire timer_compare_out_d,
    input wire timer_compare_d_enable,
    output wire [WIDTH-1:0] port_a_oe,
    output wire [WIDTH-1:0] port_a_drive,
    output wire [WIDTH-1:0] port_a_pullup,
    output wire [WIDTH-1:0] port_b_oe,
    output wire [WIDTH-1:0] port_b_drive,
    output wire [WIDTH-1:0] port_b_pullup,
    output reg [WIDTH-1:0] port_a_in,
    output reg [WIDTH-1:0] port_b_in
);
    reg [WIDTH-1:0] a_pullup_override_enable, a_pullup_override_value, a_direction_override_enable, a_direction_override_value, a_output_value_override_enable, a_output_value_override_value, a_toggle_override_enable, a_input_buffer_override_enable, a_input_buffer_override_value;
    reg [WIDTH-1:0] b_pullup_override_enable, b_pullup_override_value, b_direction_override_enable, b_direction_override_value, b_output_value_override_enable, b_output_value_override_value, b_toggle_override_enable, b_input_buffer_override_enable, b_input_buffer_override_value;
    reg [WIDTH-1:0] a_sync1, a_sync2, b_sync1, b_sync2;
    wire rst_dis;
    wire dbg_en;
    wire two_alt;
    // fuse terms read 1 when programmed (stored 0)
    assign rst_dis = (reset_pin_disable_fuse == `PAO_FUSE_PROGRAMMED);
    assign dbg_en = (debug_line_enable_fuse == `PAO_FUSE_PROGRAMMED);
    assign two_alt = serial_two_line_mode & serial_alt_position_select;

    // input buffer gating term reused by the pins with extra buffer overrides
    function buf_en;
        input pc;
        input grp;
        input dis;
        begin
            buf_en = (pc & grp) | dis;
        end
    endfunction

    always @*
    begin
        a_pullup_override_enable = `PAO_RST_BYTE;
        a_pullup_override_value = `PAO_RST_BYTE;
        a_direction_override_enable = `PAO_RST_BYTE;
        a_direction_override_value = `PAO_RST_BYTE;
        a_output_value_override_enable = `PAO_RST_BYTE;
        a_output_value_override_value = `PAO_RST_BYTE;
        a_toggle_override_enable = `PAO_RST_BYTE;
        // upper nibble and a3: buffer override only
        a_input_buffer_override_enable = (pin_change_source_a & {WIDTH{pin_change_group_enable}}) | analog_digital_disable_a;
        a_input_buffer_override_value = analog_digital_disable_a;
        a_input_buffer_override_value[`PAO_A_AREF] = `PAO_LOW;
        a_input_buffer_override_enable[`PAO_A_AREF] = pin_change_source_a[`PAO_A_AREF] & pin_change_group_enable;
        // serial clock pin
        a_direction_override_enable[`PAO_A_SCL] = two_alt;
        a_direction_override_value[`PAO_A_SCL] = (serial_clock_hold | port_b_out[`PAO_B_SCK]) & port_b_dir[`PAO_B_SCK]
            & serial_alt_position_select;
        a_output_value_override_enable[`PAO_A_SCL] = serial_two_line_mode & port_b_dir[`PAO_B_SCK];
        a_toggle_override_enable[`PAO_A_SCL] = serial_clock_toggle_enable & serial_alt_position_select;
        a_input_buffer_override_enable[`PAO_A_SCL] = buf_en(pin_change_source_a[`PAO_A_SCL], pin_change_group_enable,
            analog_digital_disable_a[`PAO_A_SCL]) | external_irq_one
            | (start_detect_irq_enable & serial_alt_position_select);
        // serial data out pin in three-line mode
        a_output_value_override_enable[`PAO_A_DO] = serial_three_line_mode & serial_alt_position_select;
        a_output_value_override_value[`PAO_A_DO] = serial_data_out & serial_alt_position_select;
        // serial data pin; open drain: only pulls low
        a_direction_override_enable[`PAO_A_SDA] = two_alt;
        a_direction_override_value[`PAO_A_SDA] = (serial_data_hold | port_b_out[`PAO_B_DI]) & port_b_dir[`PAO_B_DI]
            & serial_alt_position_select;
        a_output_value_override_enable[`PAO_A_SDA] = two_alt & port_b_dir[`PAO_B_DI];
        a_output_value_override_value[`PAO_A_SDA] = `PAO_LOW;
        a_input_buffer_override_enable[`PAO_A_SDA] = buf_en(pin_change_source_a[`PAO_A_SDA], pin_change_group_enable,
            analog_digital_disable_a[`PAO_A_SDA]) | (start_detect_irq_enable & serial_alt_position_select);
        a_input_buffer_override_value[`PAO_A_SDA] = analog_digital_disable_a[`PAO_A_SDA];
    end

    always @*
    begin
        b_pullup_override_enable = `PAO_RST_BYTE;
        b_pullup_override_value = `PAO_RST_BYTE;
        b_direction_override_enable = `PAO_RST_BYTE;
        b_direction_override_value = `PAO_RST_BYTE;
        b_output_value_override_enable = `PAO_RST_BYTE;
        b_output_value_override_value = `PAO_RST_BYTE;
        b_toggle_override_enable = `PAO_RST_BYTE;
        b_input_buffer_override_enable = (pin_change_source_b & {WIDTH{pin_change_group_enable}}) | analog_digital_disable_b;
        b_input_buffer_override_value = analog_digital_disable_b;
        // reset / debug pin
        b_pullup_override_enable[`PAO_B_DBG] = rst_dis & dbg_en;
        b_pullup_override_value[`PAO_B_DBG] = `PAO_HIGH;
        b_direction_override_enable[`PAO_B_DBG] = rst_dis & dbg_en;
        b_direction_override_value[`PAO_B_DBG] = debug_line_transmit;
        b_input_buffer_override_enable[`PAO_B_DBG] = `PAO_LOW;
        b_input_buffer_override_enable[`PAO_B_RST] = rst_dis | buf_en(pin_change_source_b[`PAO_B_RST], pin_change_group_enable,
            analog_digital_disable_b[`PAO_B_RST]);
        // oscillator pins take the pad away from the port
        b_pullup_override_enable[`PAO_B_CLKO] = internal_oscillator_select & external_clock_select;
        b_direction_override_enable[`PAO_B_CLKO] = internal_oscillator_select & external_clock_select;
        b_input_buffer_override_enable[`PAO_B_CLKO] = (internal_oscillator_select & external_clock_select)
            | buf_en(pin_change_source_b[`PAO_B_CLKO], pin_change_group_enable,
            analog_digital_disable_b[`PAO_B_CLKO]);
        b_input_buffer_override_value[`PAO_B_CLKO] = (internal_oscillator_select & external_clock_select)
            | analog_digital_disable_b[`PAO_B_CLKO];
        b_pullup_override_enable[`PAO_B_XTAL] = internal_oscillator_select;
        b_direction_override_enable[`PAO_B_XTAL] = internal_oscillator_select;
        b_input_buffer_override_enable[`PAO_B_XTAL] = internal_oscillator_select | buf_en(pin_change_source_b[`PAO_B_XTAL],
            pin_change_group_enable, analog_digital_disable_b[`PAO_B_XTAL]);
        b_input_buffer_override_value[`PAO_B_XTAL] = internal_oscillator_select & analog_digital_disable_b[`PAO_B_XTAL];
        // compare output d on both oscillator pins
        b_output_value_override_enable[`PAO_B_CLKO] = timer_compare_d_enable;
        b_output_value_override_value[`PAO_B_CLKO] = timer_compare_out_d;
        b_output_value_override_enable[`PAO_B_XTAL] = timer_compare_d_enable;
        b_output_value_override_value[`PAO_B_XTAL] = timer_compare_out_d;
        // b1: three-line output wins over compare output; direction stays with port
        if (serial_three_line_mode)
        begin
            b_output_value_override_enable[`PAO_B_DO] = `PAO_HIGH;
            b_output_value_override_value[`PAO_B_DO] = serial_data_out;
        end
        else if (timer_compare_a_enable)
        begin
            b_output_value_override_enable[`PAO_B_DO] = `PAO_HIGH;
            b_output_value_override_value[`PAO_B_DO] = timer_compare_out_a;
        end
        // b0: no override in three-line mode, software keeps it input
        if (timer_compare_a_enable & ~serial_three_line_mode)
        begin
            b_output_value_override_enable[`PAO_B_DI] = `PAO_HIGH;
            b_output_value_override_value[`PAO_B_DI] = ~timer_compare_out_a;
        end
    end

    // pull-up of b1 uses the unoverridden port bit, so it survives serial output
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_pin
            pao_pin u_a (
                .ref_clk(ref_clk),
                .rst(rst),
                .pullup_override_enable(a_pullup_override_enable[i]),
                .pullup_override_value(a_pullup_override_value[i]),
                .direction_override_enable(a_direction_override_enable[i]),
                .direction_override_value(a_direction_override_value[i]),
                .output_value_override_enable(a_output_value_override_enable[i]),
                .output_value_override_value(a_output_value_override_value[i]),
                .toggle_override_enable(a_toggle_override_enable[i]),
                .port_dir(port_a_dir[i]),
                .port_out(port_a_out[i]),
                .pullup_disable(pullup_disable),
                .pad_oe(port_a_oe[i]),
                .pad_out(port_a_drive[i]),
                .pad_pullup(port_a_pullup[i])
            );
            pao_pin u_b (
                .ref_clk(ref_clk),
                .rst(rst),
                .pullup_override_enable(b_pullup_override_enable[i]),
                .pullup_override_value(b_pullup_override_value[i]),
                .direction_override_enable(b_direction_override_enable[i]),
                .direction_override_value(b_direction_override_value[i]),
                .output_value_override_enable(b_output_value_override_enable[i]),
                .output_value_override_value(b_output_value_override_value[i]),
                .toggle_override_enable(b_toggle_override_enable[i]),
                .port_dir(port_b_dir[i]),
                .port_out(port_b_out[i]),
                .pullup_disable(pullup_disable),
                .pad_oe(port_b_oe[i]),
                .pad_out(port_b_drive[i]),
                .pad_pullup(port_b_pullup[i])
            );
        end
    endgenerate

    // pad inputs cross in through two sync flops, then the port_a_in/port_b_in register; disabled buffers read the override value
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            a_sync1 <= `PAO_RST_BYTE;
            a_sync2 <= `PAO_RST_BYTE;
            b_sync1 <= `PAO_RST_BYTE;
            b_sync2 <= `PAO_RST_BYTE;
            port_a_in <= `PAO_RST_BYTE;
            port_b_in <= `PAO_RST_BYTE;
        end
        else
        begin
            a_sync1 <= port_a_pin;
            a_sync2 <= a_sync1;
            b_sync1 <= port_b_pin;
            b_sync2 <= b_sync1;
            port_a_in <= (a_input_buffer_override_enable & a_input_buffer_override_value) | (~a_input_buffer_override_enable & a_sync2);
            port_b_in <= (b_input_buffer_override_enable & b_input_buffer_override_value) | (~b_input_buffer_override_enable & b_sync2);
        end
    end
endmodule
`default_nettype wire

// >>> hdl/pao_defs.vh
// constants for the port alternate-function override block
`ifndef PAO_DEFS_VH
`define PAO_DEFS_VH
`define PAO_PORT_WIDTH 8
`define PAO_A_AREF 3
`define PAO_A_SCL 2
`define PAO_A_DO 1
`define PAO_A_SDA 0
`define PAO_B_DBG 7
`define PAO_B_RST 6
`define PAO_B_CLKO 5
`define PAO_B_XTAL 4
`define PAO_B_SCK 2
`define PAO_B_DO 1
`define PAO_B_DI 0
`define PAO_FUSE_PROGRAMMED 1'b0
`define PAO_LOW 1'b0
`define PAO_HIGH 1'b1
`define PAO_RST_BYTE 8'h00
`endif

// >>> hdl/pao_pin.v
// one pin's override merge plus registered pad controls
`include "pao_defs.vh"
`default_nettype none
module pao_pin (
    input wire ref_clk,
    input wire rst,
    input wire pullup_override_enable,
    input wire pullup_override_value,
    input wire direction_override_enable,
    input wire direction_override_value,
    input wire output_value_override_enable,
    input wire output_value_override_value,
    input wire toggle_override_enable,
    input wire port_dir,
    input wire port_out,
    input wire pullup_disable,
    output reg pad_oe,
    output reg pad_out,
    output reg pad_pullup
);
    wire dir;
    wire val;
    reg toggle_state;
    // override value replaces the port register setting when enabled
    assign dir = direction_override_enable ? direction_override_value : port_dir;
    assign val = output_value_override_enable ? output_value_override_value : port_out;
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pad_oe <= `PAO_LOW;
            pad_out <= `PAO_LOW;
            pad_pullup <= `PAO_LOW;
            toggle_state <= `PAO_LOW;
        end
        else
        begin
            // toggle override XORs the driven level with toggle_state, which starts low and flips each cycle the override is asserted
            if (toggle_override_enable)
                toggle_state <= ~toggle_state;
            pad_oe <= dir;
            pad_out <= val ^ (toggle_override_enable & toggle_state);
            // pull-up only for inputs with a high port bit, unless overridden
            pad_pullup <= pullup_override_enable ? pullup_override_value
                        : (~dir & port_out & ~pullup_disable);
        end
    end
endmodule
`default_nettype wire

// >>> tb/pao_pad_model.sv
// pad model for both ports: driven, pulled up or floating lines
`default_nettype none
module pao_pad_model (
    input wire logic ref_clk,
    input wire logic [7:0] port_a_oe,
    input wire logic [7:0] port_a_drive,
    input wire logic [7:0] port_a_pullup,
    input wire logic [7:0] port_b_oe,
    input wire logic [7:0] port_b_drive,
    input wire logic [7:0] port_b_pullup,
    output logic [7:0] port_a_pin,
    output logic [7:0] port_b_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // a floating line wobbles so a stale value never passes as real
    logic [7:0] wobble = 8'h5a;
    always @(posedge ref_clk) wobble <= ~wobble;
    always_comb
    begin
        port_a_pin = (port_a_oe & port_a_drive) | (~port_a_oe & (port_a_pullup | wobble));
        port_b_pin = (port_b_oe & port_b_drive) | (~port_b_oe & (port_b_pullup | wobble));
    end
endmodule
`default_nettype wire

// >>> tb/pao_top_monitor.sv
// concurrent checks on the port override block
`default_nettype none
module pao_top_monitor #(parameter WIDTH = 8) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] port_a_dir,
    input wire logic [WIDTH-1:0] port_b_dir,
    input wire logic [WIDTH-1:0] port_b_out,
    input wire logic pullup_disable,
    input wire logic [WIDTH-1:0] pin_change_source_a,
    input wire logic pin_change_group_enable,
    input wire logic [WIDTH-1:0] analog_digital_disable_a,
    input wire logic [WIDTH-1:0] analog_digital_disable_b,
    input wire logic serial_alt_position_select,
    input wire logic serial_two_line_mode,
    input wire logic serial_three_line_mode,
    input wire logic serial_clock_hold,
    input wire logic serial_data_out,
    input wire logic serial_data_hold,
    input wire logic reset_pin_disable_fuse,
    input wire logic debug_line_enable_fuse,
    input wire logic debug_line_transmit,
    input wire logic timer_compare_out_a,
    input wire logic timer_compare_a_enable,
    input wire logic [WIDTH-1:0] port_a_oe,
    input wire logic [WIDTH-1:0] port_a_drive,
    input wire logic [WIDTH-1:0] port_b_oe,
    input wire logic [WIDTH-1:0] port_b_drive,
    input wire logic [WIDTH-1:0] port_b_pullup,
    input wire logic [WIDTH-1:0] port_a_in,
    input wire logic [WIDTH-1:0] port_b_in
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // past values from inside reset are not trusted
    logic live;
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            live <= 1'b0;
        else
            live <= 1'b1;
    end
    sequence debug_fused;
        live ##0 $past(!reset_pin_disable_fuse && !debug_line_enable_fuse);
    endsequence
    a_upper_a_plain: assert property (live |-> port_a_oe[7:4] == $past(port_a_dir[7:4]))
        else $error("upper port a direction overridden");
    a_a7_buffer: assert property (live && $past(pin_change_source_a[7] && pin_change_group_enable)
        |-> port_a_in[7] == $past(analog_digital_disable_a[7])) else $error("a7 buffer value wrong");
    a_a2_clock_dir: assert property (live && $past(serial_two_line_mode && serial_alt_position_select)
        |-> port_a_oe[2] == $past((serial_clock_hold | port_b_out[2]) & port_b_dir[2]))
        else $error("a2 direction override wrong");
    a_a0_pull_low: assert property (live
        && $past(serial_two_line_mode && serial_alt_position_select && port_b_dir[0])
        |-> !port_a_drive[0] && port_a_oe[0] == $past(serial_data_hold | port_b_out[0]))
        else $error("a0 data pin drove high or wrong direction");
    a_b6_buffer: assert property (live && $past(!reset_pin_disable_fuse)
        |-> port_b_in[6] == $past(analog_digital_disable_b[6])) else $error("b6 buffer value wrong");
    a_debug_pin: assert property (debug_fused |-> port_b_pullup[7] && port_b_oe[7] == $past(debug_line_transmit))
        else $error("b7 debug override wrong");
    a_b1_three_line: assert property (live && $past(serial_three_line_mode && port_b_dir[1])
        |-> port_b_oe[1] && port_b_drive[1] == $past(serial_data_out)) else $error("b1 serial out wrong");
    a_b1_pullup_keep: assert property (live && $past(!port_b_dir[1] && port_b_out[1] && !pullup_disable)
        |-> port_b_pullup[1]) else $error("b1 pull-up lost");
    a_b1_compare: assert property (live
        && $past(!serial_three_line_mode && timer_compare_a_enable && port_b_dir[1])
        |-> port_b_drive[1] == $past(timer_compare_out_a)) else $error("b1 compare wrong");
    a_b0_inverted: assert property (live
        && $past(timer_compare_a_enable && port_b_dir[0] && !serial_two_line_mode && !serial_three_line_mode)
        |-> port_b_drive[0] != $past(timer_compare_out_a)) else $error("b0 inverted compare wrong");
endmodule
bind pao_top pao_top_monitor #(.WIDTH(WIDTH)) u_pao_top_monitor (.*);
`default_nettype wire

// >>> tb/tb_pao_top.sv
// self-checking bench for the port override block
`default_nettype none
module tb_pao_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rst, pullup_disable, pin_change_group_enable, serial_alt_position_select;
    logic serial_two_line_mode, serial_three_line_mode, serial_clock_hold, serial_clock_toggle_enable;
    logic serial_data_out, serial_data_hold, start_detect_irq_enable, external_irq_one;
    logic reset_pin_disable_fuse, debug_line_enable_fuse, debug_line_transmit;
    logic internal_oscillator_select, external_clock_select, timer_compare_out_a, timer_compare_a_enable;
    logic timer_compare_out_d, timer_compare_d_enable;
    logic [7:0] port_a_dir, port_a_out, port_b_dir, port_b_out, port_a_pin, port_b_pin;
    logic [7:0] pin_change_source_a, pin_change_source_b, analog_digital_disable_a, analog_digital_disable_b;
    wire logic [7:0] port_a_oe, port_a_drive, port_a_pullup, port_b_oe, port_b_drive, port_b_pullup;
    wire logic [7:0] port_a_in, port_b_in;
    int n_mismatch = 0;
    int num_checks = 0;
    pao_top u_pao_top (.*);
    pao_pad_model u_pao_pad_model (.*);
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #20000;
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        {port_a_dir, port_a_out, port_b_dir, port_b_out, pin_change_source_a, pin_change_source_b} = '0;
        {analog_digital_disable_a, analog_digital_disable_b, pullup_disable, pin_change_group_enable} = '0;
        {serial_alt_position_select, serial_two_line_mode, serial_three_line_mode, serial_clock_hold} = '0;
        {serial_clock_toggle_enable, serial_data_out, serial_data_hold, start_detect_irq_enable} = '0;
        {external_irq_one, debug_line_transmit, internal_oscillator_select, external_clock_select} = '0;
        {timer_compare_out_a, timer_compare_a_enable, timer_compare_out_d, timer_compare_d_enable} = '0;
        {reset_pin_disable_fuse, debug_line_enable_fuse} = 2'h3;
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("b_oe in reset", 8'h00, port_b_oe);
        rst = 1'b0;
        // b0 kept input while three-line mode runs
        port_b_dir = 8'h02;
        serial_three_line_mode = 1'b1;
        for (int v = 1; v >= 0; v--)
        begin
            serial_data_out = v[0];
            @(negedge ref_clk);
            check("b1 serial out", {6'h00, v[0], 1'b1}, {port_b_drive[7:2] & 6'h00, port_b_drive[1], port_b_oe[1]});
        end
        port_b_dir = 8'h00;
        port_b_out = 8'h02;
        @(negedge ref_clk);
        check("b1 pull-up", 8'h02, port_b_pullup & 8'h02);
        serial_three_line_mode = 1'b0;
        port_b_out = 8'h00;
        port_b_dir = 8'h03;
        timer_compare_a_enable = 1'b1;
        for (int v = 0; v < 2; v++)
        begin
            timer_compare_out_a = v[0];
            @(negedge ref_clk);
            check("b1/b0 compare", v[0] ? 8'h02 : 8'h01, port_b_drive & 8'h03);
        end
        timer_compare_d_enable = 1'b1;
        port_b_dir = 8'h30;
        debug_line_enable_fuse = 1'b0;
        reset_pin_disable_fuse = 1'b0;
        pullup_disable = 1'b1;
        for (int v = 0; v < 2; v++)
        begin
            timer_compare_out_d = v[0];
            debug_line_transmit = v[0];
            @(negedge ref_clk);
            check("b5/b4 compare", v[0] ? 8'h30 : 8'h00, port_b_drive & 8'h30);
            check("b7 debug", v[0] ? 8'h81 : 8'h01, {port_b_oe[7], 6'h00, port_b_pullup[7]});
        end
        // serial pins on port a take their direction from the b2/b0 bits
        {serial_two_line_mode, serial_alt_position_select, serial_data_hold} = 3'h7;
        {port_b_dir, port_b_out} = {8'h05, 8'h04};
        @(negedge ref_clk);
        check("a serial oe", 8'h05, port_a_oe & 8'h05);
        check("a0 pull low", 8'h00, port_a_drive & 8'h01);
        {serial_clock_hold, serial_data_hold, port_b_out} = {2'h2, 8'h00};
        @(negedge ref_clk);
        check("a serial oe hold", 8'h04, port_a_oe & 8'h05);
        serial_two_line_mode = 1'b0;
        {pin_change_source_a, pin_change_group_enable, external_irq_one, start_detect_irq_enable} = {8'h80, 3'h7};
        for (int v = 0; v < 2; v++)
        begin
            analog_digital_disable_a = v[0] ? 8'h00 : 8'h85;
            @(negedge ref_clk);
            check("a buffer", analog_digital_disable_a, port_a_in & 8'h85);
        end
        {internal_oscillator_select, external_clock_select, debug_line_enable_fuse} = 3'h7;
        analog_digital_disable_b = 8'h50;
        @(negedge ref_clk);
        check("b buffer", 8'h70, port_b_in & 8'h70);
        analog_digital_disable_b = 8'h00;
        @(negedge ref_clk);
        check("b buffer clear", 8'h20, port_b_in & 8'h70);
        // plain port a: pull-up, drive, then readback through the synchroniser
        {pullup_disable, port_a_out} = {1'b0, 8'ha5};
        @(negedge ref_clk);
        check("a pull-up", 8'ha5, port_a_pullup);
        port_a_dir = 8'hff;
        repeat (4) @(negedge ref_clk);
        check("a drive", 8'ha5, port_a_drive);
        check("a pin in", 8'h20, port_a_in & 8'h7a);
        // toggle flop starts low, so the first enabled cycle keeps the level
        serial_clock_toggle_enable = 1'b1;
        for (int v = 1; v >= 0; v--)
        begin
            @(negedge ref_clk);
            check("a2 toggle", v[0] ? 8'h04 : 8'h00, port_a_drive & 8'h04);
        end
        stop_test();
    end
endmodule
`default_nettype wire
